/* gcr_pkg.sv */
// Package for the gyro control register bank.
// Assumes a single 40 MHz system clock domain.
package gcr_pkg;
	localparam logic [5:0] ADDR_ENDURANCE = 6'h00;
	localparam logic [5:0] ADDR_RATE_OUT  = 6'h04;
	localparam logic [5:0] ADDR_ANGLE_OUT = 6'h0E;
	localparam logic [5:0] ADDR_OFFSET    = 6'h10;
	localparam logic [5:0] ADDR_SCALE     = 6'h12;
	localparam logic [5:0] ADDR_ALM_THR1  = 6'h20;
	localparam logic [5:0] ADDR_ALM_THR2  = 6'h22;
	localparam logic [5:0] ADDR_ALM_PER1  = 6'h24;
	localparam logic [5:0] ADDR_ALM_PER2  = 6'h26;
	localparam logic [5:0] ADDR_ALARM_SOURCE_CONTROL  = 6'h28;
	localparam logic [5:0] ADDR_AUX_DAC   = 6'h30;
	localparam logic [5:0] ADDR_PIN_IO    = 6'h32;
	localparam logic [5:0] ADDR_MISC      = 6'h34;
	localparam logic [5:0] ADDR_SAMPLE_PERIOD_CONTROL  = 6'h36;
	localparam logic [5:0] ADDR_RANGE_FLT = 6'h38;
	localparam logic [5:0] ADDR_SLEEP     = 6'h3A;
	localparam logic [5:0] ADDR_STATUS    = 6'h3C;
	localparam logic [5:0] ADDR_COMMAND   = 6'h3E;
	localparam logic [5:0] ADDR_RSVD1_LO  = 6'h18;
	localparam logic [5:0] ADDR_RSVD1_HI  = 6'h1F;
	localparam logic [5:0] ADDR_RSVD2_LO  = 6'h2A;
	localparam logic [5:0] ADDR_RSVD2_HI  = 6'h2F;

	localparam int NUM_REGS  = 32;
	localparam int NV_WORDS  = 10;

	localparam logic [15:0] RST_OFFSET    = 16'h0000;
	localparam logic [15:0] RST_SCALE     = 16'h0800;
	localparam logic [15:0] RST_SAMPLE_PERIOD_CONTROL  = 16'h0001;
	localparam logic [15:0] RST_RANGE_FLT = 16'h0402;
	localparam logic [15:0] RST_ZERO      = 16'h0000;
	localparam logic [15:0] CAL_MASK      = 16'h0FFF;
	localparam logic [15:0] MISC_NV_MASK  = 16'hFF00;

	localparam int CMD_AUTO_NULL   = 0;
	localparam int CMD_FACTORY     = 1;
	localparam int CMD_DAC_LATCH   = 2;
	localparam int CMD_FLASH_UPD   = 3;
	localparam int CMD_SOFT_RESET  = 7;

	localparam int FRAME_BITS   = 16;
	localparam int FLASH_MS     = 50;
	localparam int CLK_HZ       = 40_000_000;
	localparam int FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [5:0] addr;
		logic [7:0] data;
	} gcr_frame_s;

	typedef enum logic [1:0] {
		GCR_IDLE,
		GCR_LOAD,
		GCR_STORE
	} gcr_nv_e;
endpackage

/* gcr_spi_frame.sv */
// Serial frame receiver and transmitter for the register bank.
// Assumes mode 3 SPI pins from the host; all pins are resynchronised to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module gcr_spi_frame (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               cs_n,
	input  wire logic               sclk,
	input  wire logic               din,
	input  wire logic [15:0]        tx_word,
	output gcr_pkg::gcr_frame_s     frame,
	output logic                    dout,
	output logic                    dout_oe_n
);
	logic [1:0]  cs_sync_q, sclk_sync_q, din_sync_q;
	logic        sclk_prev_q;
	logic [15:0] rx_q, tx_q;
	logic [4:0]  cnt_q;
	wire  cs_act  = ~cs_sync_q[1];
	wire  rise    = sclk_sync_q[1] & ~sclk_prev_q;
	wire  fall    = ~sclk_sync_q[1] & sclk_prev_q;
	wire  last    = rise && (cnt_q == 5'(gcr_pkg::FRAME_BITS - 1));
	wire  [15:0] rx_full = {rx_q[14:0], din_sync_q[1]};

	always_ff @(posedge clk_sys) begin
		cs_sync_q   <= {cs_sync_q[0], cs_n};
		sclk_sync_q <= {sclk_sync_q[0], sclk};
		din_sync_q  <= {din_sync_q[0], din};
		sclk_prev_q <= sclk_sync_q[1];
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !cs_act) begin
			cnt_q <= '0;
			rx_q  <= '0;
			tx_q  <= tx_word;
			frame <= '0;
		end else begin
			frame <= '0;
			if (rise) begin
				rx_q  <= rx_full;
				cnt_q <= cnt_q + 5'd1;
			end
			// The first falling edge only launches bit 15, which already stands on dout
			if (fall && cnt_q != 5'd0)
				tx_q <= {tx_q[14:0], 1'b0};
			if (last) begin
				// Bit 15 set means a write clear means a read request
				frame.valid <= 1'b1;
				frame.write <= rx_full[15];
				frame.addr  <= rx_full[13:8];
				frame.data  <= rx_full[7:0];
			end
		end
	end

	assign dout      = tx_q[15];
	assign dout_oe_n = ~cs_act;
endmodule
`default_nettype wire

/* gcr_regs.sv */
// Control register bank of a rate gyro with global commands and flash copy.
// Assumes host is SPI master; flash array is modelled as an on-chip word array.
`timescale 1ns/100ps
`default_nettype none
module gcr_regs #(
	parameter int FLASH_CYCLES = gcr_pkg::FLASH_CYCLES
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               cs_n,
	input  wire logic               sclk,
	input  wire logic               din,
	output logic                    dout,
	output logic                    dout_oe_n,
	input  wire logic signed [13:0] raw_rate,
	input  wire logic        [15:0] status_in,
	output logic signed [13:0]      cal_rate,
	output logic                    angle_clear,
	output logic        [11:0]      dac_latch_q,
	output logic        [15:0]      alarm1_threshold,
	output logic        [15:0]      alarm2_threshold,
	output logic        [15:0]      alarm1_sample_period,
	output logic        [15:0]      alarm2_sample_period,
	output logic        [15:0]      alarm_source_control,
	output logic        [15:0]      pin_io_control,
	output logic        [15:0]      misc_control,
	output logic        [15:0]      sample_period_control,
	output logic        [15:0]      range_and_filter_control,
	output logic        [15:0]      sleep_duration,
	output logic                    flash_busy
);
	// Word array indexed by address bits 5:1; unused slots are optimised away
	logic [15:0] regs_q [gcr_pkg::NUM_REGS];
	logic [15:0] flash_q [gcr_pkg::NV_WORDS];
	logic [15:0] endurance_q;
	logic [15:0] tx_q;
	logic [31:0] busy_cnt_q;
	logic [3:0]  nv_idx_q;
	logic        soft_rst_q;
	// Low only from configuration until the first reload ends; marks the cold start
	logic        powered_q = 1'b0;
	gcr_pkg::gcr_nv_e   nv_q;
	gcr_pkg::gcr_frame_s frame;

	gcr_spi_frame u_spi (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.cs_n      (cs_n),
		.sclk      (sclk),
		.din       (din),
		.tx_word   (tx_q),
		.frame     (frame),
		.dout      (dout),
		.dout_oe_n (dout_oe_n)
	);

	wire       int_rst = rst | soft_rst_q;
	wire [4:0] widx    = frame.addr[5:1];
	wire       hi_byte = frame.addr[0];
	wire       wr      = frame.valid & frame.write;
	wire       is_cmd  = (frame.addr[5:1] == gcr_pkg::ADDR_COMMAND[5:1]);
	wire       is_stat = (frame.addr[5:1] == gcr_pkg::ADDR_STATUS[5:1]);
	wire       rsvd    = (frame.addr >= gcr_pkg::ADDR_RSVD1_LO && frame.addr <= gcr_pkg::ADDR_RSVD1_HI)
	                   || (frame.addr >= gcr_pkg::ADDR_RSVD2_LO
	                   && frame.addr <= gcr_pkg::ADDR_RSVD2_HI);
	wire       mapped  = (frame.addr >= gcr_pkg::ADDR_OFFSET) && !rsvd;
	wire       reg_wr  = wr && mapped && !is_cmd && !is_stat;
	// Low byte of command word carries every trigger bit
	wire       cmd_ok  = wr && is_cmd && !hi_byte && !flash_busy;
	wire [7:0] cmd     = cmd_ok ? frame.data : 8'h00;
	wire       do_null = cmd[gcr_pkg::CMD_AUTO_NULL];
	wire       do_fact = cmd[gcr_pkg::CMD_FACTORY];
	wire       do_dac  = cmd[gcr_pkg::CMD_DAC_LATCH];
	wire       do_fl   = cmd[gcr_pkg::CMD_FLASH_UPD] | do_null | do_fact;
	wire       do_srst = cmd[gcr_pkg::CMD_SOFT_RESET];

	// Nonvolatile word slots in flash order
	function automatic logic [4:0] nv_slot(input logic [3:0] i);
		logic [5:0] a;
		a = gcr_pkg::ADDR_OFFSET;
		case (i)
			4'h0: a = gcr_pkg::ADDR_OFFSET;
			4'h1: a = gcr_pkg::ADDR_SCALE;
			4'h2: a = gcr_pkg::ADDR_ALM_THR1;
			4'h3: a = gcr_pkg::ADDR_ALM_THR2;
			4'h4: a = gcr_pkg::ADDR_ALM_PER1;
			4'h5: a = gcr_pkg::ADDR_ALM_PER2;
			4'h6: a = gcr_pkg::ADDR_ALARM_SOURCE_CONTROL;
			4'h7: a = gcr_pkg::ADDR_MISC;
			4'h8: a = gcr_pkg::ADDR_SAMPLE_PERIOD_CONTROL;
			4'h9: a = gcr_pkg::ADDR_RANGE_FLT;
			default: a = gcr_pkg::ADDR_OFFSET;
		endcase
		return a[5:1];
	endfunction

	function automatic logic [15:0] reset_val(input logic [4:0] w);
		logic [15:0] v;
		v = gcr_pkg::RST_ZERO;
		if (w == gcr_pkg::ADDR_SCALE[5:1])
			v = gcr_pkg::RST_SCALE;
		else if (w == gcr_pkg::ADDR_SAMPLE_PERIOD_CONTROL[5:1])
			v = gcr_pkg::RST_SAMPLE_PERIOD_CONTROL;
		else if (w == gcr_pkg::ADDR_RANGE_FLT[5:1])
			v = gcr_pkg::RST_RANGE_FLT;
		return v;
	endfunction

	// y = m*x + b, m has 11 fractional bits
	wire signed [26:0] prod     = raw_rate * $signed({1'b0, regs_q[gcr_pkg::ADDR_SCALE[5:1]][11:0]});
	wire signed [15:0] scaled   = 16'(prod >>> 11);
	wire signed [15:0] bias     = 16'($signed(regs_q[gcr_pkg::ADDR_OFFSET[5:1]][11:0]));
	wire signed [15:0] sum      = scaled + bias;
	wire signed [15:0] neg_rate = -16'(raw_rate);
	wire        [15:0] null_off = neg_rate & gcr_pkg::CAL_MASK;

	always_ff @(posedge clk_sys) begin
		cal_rate <= 14'(sum);
	end

	// Register file: reset defaults, then flash reload, commands and bytes
	for (genvar w = 0; w < gcr_pkg::NUM_REGS; w++) begin : g_reg
		wire is_off = (5'(w) == gcr_pkg::ADDR_OFFSET[5:1]);
		wire is_scl = (5'(w) == gcr_pkg::ADDR_SCALE[5:1]);
		wire is_msc = (5'(w) == gcr_pkg::ADDR_MISC[5:1]);
		wire cal    = is_off | is_scl;
		always_ff @(posedge clk_sys) begin
			if (int_rst) begin
				regs_q[w] <= reset_val(5'(w));
			end else if (nv_q == gcr_pkg::GCR_LOAD && nv_slot(nv_idx_q) == 5'(w)) begin
				if (is_msc)
					regs_q[w] <= (flash_q[nv_idx_q] & gcr_pkg::MISC_NV_MASK)
					           | (regs_q[w] & ~gcr_pkg::MISC_NV_MASK);
				else
					regs_q[w] <= flash_q[nv_idx_q];
			end else if (do_fact && cal) begin
				regs_q[w] <= is_scl ? gcr_pkg::RST_SCALE : gcr_pkg::RST_OFFSET;
			end else if (do_null && is_off) begin
				regs_q[w] <= null_off;
			end else if (reg_wr && widx == 5'(w)) begin
				if (hi_byte)
					regs_q[w][15:8] <= cal ? 8'(frame.data[3:0]) : frame.data;
				else
					regs_q[w][7:0] <= frame.data;
			end
		end
	end

	// Flash: reloaded after every reset, stored on update; survives soft reset
	always_ff @(posedge clk_sys) begin
		if (rst && !powered_q) begin
			// Cold start: clear the count, then reload once reset is released
			nv_q        <= gcr_pkg::GCR_LOAD;
			nv_idx_q    <= '0;
			busy_cnt_q  <= '0;
			endurance_q <= '0;
			powered_q   <= 1'b0;
		end else if (int_rst) begin
			nv_q     <= gcr_pkg::GCR_LOAD;
			nv_idx_q <= '0;
		end else begin
			case (nv_q)
				gcr_pkg::GCR_IDLE: begin
					powered_q <= 1'b1;
					if (do_fl) begin
						nv_q       <= gcr_pkg::GCR_STORE;
						nv_idx_q   <= '0;
						busy_cnt_q <= 32'(FLASH_CYCLES);
					end
				end
				gcr_pkg::GCR_LOAD: begin
					nv_idx_q <= nv_idx_q + 4'd1;
					if (nv_idx_q == 4'(gcr_pkg::NV_WORDS - 1))
						nv_q <= gcr_pkg::GCR_IDLE;
				end
				gcr_pkg::GCR_STORE: begin
					if (nv_idx_q < 4'(gcr_pkg::NV_WORDS)) begin
						flash_q[nv_idx_q] <= regs_q[nv_slot(nv_idx_q)];
						nv_idx_q          <= nv_idx_q + 4'd1;
					end
					busy_cnt_q <= busy_cnt_q - 32'd1;
					if (busy_cnt_q == 32'd1) begin
						nv_q        <= gcr_pkg::GCR_IDLE;
						endurance_q <= endurance_q + 16'd1;
					end
				end
				default: nv_q <= gcr_pkg::GCR_IDLE;
			endcase
		end
	end

	// Self-clearing one-shot reset pulse
	always_ff @(posedge clk_sys) begin
		if (rst)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= do_srst;
	end

	always_ff @(posedge clk_sys) begin
		if (int_rst) begin
			dac_latch_q <= '0;
			angle_clear <= 1'b0;
		end else begin
			angle_clear <= do_null;
			if (do_dac)
				dac_latch_q <= regs_q[gcr_pkg::ADDR_AUX_DAC[5:1]][11:0];
		end
	end

	// Read data for the next frame; either byte address reads the whole word
	wire [15:0] rd_word =
		(frame.addr[5:1] == gcr_pkg::ADDR_ENDURANCE[5:1]) ? endurance_q :
		is_stat ? status_in :
		(is_cmd || !mapped) ? 16'h0000 : regs_q[widx];

	always_ff @(posedge clk_sys) begin
		if (int_rst)
			tx_q <= '0;
		else if (frame.valid && !frame.write)
			tx_q <= rd_word;
	end

	assign flash_busy               = (nv_q != gcr_pkg::GCR_IDLE);
	assign alarm1_threshold         = regs_q[gcr_pkg::ADDR_ALM_THR1[5:1]];
	assign alarm2_threshold         = regs_q[gcr_pkg::ADDR_ALM_THR2[5:1]];
	assign alarm1_sample_period     = regs_q[gcr_pkg::ADDR_ALM_PER1[5:1]];
	assign alarm2_sample_period     = regs_q[gcr_pkg::ADDR_ALM_PER2[5:1]];
	assign alarm_source_control     = regs_q[gcr_pkg::ADDR_ALARM_SOURCE_CONTROL[5:1]];
	assign pin_io_control           = regs_q[gcr_pkg::ADDR_PIN_IO[5:1]];
	assign misc_control             = regs_q[gcr_pkg::ADDR_MISC[5:1]];
	assign sample_period_control    = regs_q[gcr_pkg::ADDR_SAMPLE_PERIOD_CONTROL[5:1]];
	assign range_and_filter_control = regs_q[gcr_pkg::ADDR_RANGE_FLT[5:1]];
	assign sleep_duration           = regs_q[gcr_pkg::ADDR_SLEEP[5:1]];
endmodule
`default_nettype wire

/* gcr_props.sv */
// Checker for the gyro register bank, bound to its top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module gcr_props #(
	parameter int FLASH_CYCLES = gcr_pkg::FLASH_CYCLES
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        dout_oe_n,
	input wire logic        angle_clear,
	input wire logic        flash_busy,
	input wire logic [11:0] dac_latch_q,
	input wire logic [15:0] pin_io_control,
	input wire logic [15:0] sleep_duration,
	input wire logic [15:0] sample_period_control,
	input wire logic [15:0] range_and_filter_control
);
	int busy_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys) busy_cnt <= (rst || !flash_busy) ? 0 : busy_cnt + 1;
	sequence s_quiet;
		cs_n [*8];
	endsequence
	sequence s_busy_start;
		$rose(flash_busy);
	endsequence
	AST_OE_IDLE: assert property (s_quiet |-> dout_oe_n)
		else $error("dout driven while idle");
	AST_STAND: assert property (s_quiet |-> $stable(pin_io_control)
		&& $stable(sleep_duration) && $stable(dac_latch_q)) else $error("idle change");
	AST_ANGLE_ONE: assert property (angle_clear |=> !angle_clear)
		else $error("angle clear too long");
	AST_NULL_STORE: assert property (angle_clear |-> ##[0:8] flash_busy)
		else $error("no store after null");
	AST_BUSY_MIN: assert property (s_busy_start |-> flash_busy [*8])
		else $error("flash op too short");
	AST_BUSY_MAX: assert property (busy_cnt <= FLASH_CYCLES + 16)
		else $error("flash op too long");
	AST_RELOAD: assert property ($fell(rst) |-> ##[0:3] flash_busy)
		else $error("no reload after reset");
	AST_RST_DEF: assert property (disable iff (1'b0) rst [*2] |->
		sample_period_control == 16'h0001 && range_and_filter_control == 16'h0402
		&& pin_io_control == 16'h0000 && sleep_duration == 16'h0000) else $error("bad default");
endmodule
bind gcr_regs gcr_props #(.FLASH_CYCLES(FLASH_CYCLES)) gcr_props_inst (.clk_sys, .rst, .cs_n,
	.dout_oe_n, .angle_clear, .flash_busy, .dac_latch_q, .pin_io_control, .sleep_duration,
	.sample_period_control, .range_and_filter_control);
`default_nettype wire

/* gcr_host.sv */
// Host model: mode 3 serial master moving one 16-bit frame per call.
// Assumes clk_sys is the device clock; sclk half period is four of its cycles.
`timescale 1ns/100ps
`default_nettype none
module gcr_host (
	input  wire logic clk_sys,
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe_n
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	// Deselected, din toggles so a stale bit never passes as valid
	always @(posedge clk_sys) if (cs_n) din <= #1 ~din;
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge clk_sys) #1 cs_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int i = 15; i >= 0; i--) begin
			#1 sclk = 1'b0;
			din = tx[i];
			repeat (4) @(posedge clk_sys);
			#1 rx[i] = dout_oe_n ? 1'bz : dout;
			sclk = 1'b1;
			repeat (4) @(posedge clk_sys);
		end
		#1 cs_n = 1'b1;
		repeat (12) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Testbench: drives the register bank through the host model against a model.
// Assumes a short flash time so that store and reload fit in the run.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int FC = 400;
	logic               clk_sys, rst, cs_n, sclk, din, dout, dout_oe_n, angle_clear, flash_busy;
	logic signed [13:0] raw_rate, cal_rate;
	logic        [11:0] dac_latch_q;
	logic        [15:0] status_in, rx, rp [10], m [32];
	logic        [5:0]  pa [10] = '{6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h32, 6'h34, 6'h36,
		6'h38, 6'h3A};
	int                 n_fail = 0, tests_run = 0, n_end = 0, n_clr = 0, e;
	int                 seed = 32'h7DD2B4AB;
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	gcr_regs #(.FLASH_CYCLES(FC)) gcr_regs_inst (.clk_sys, .rst, .cs_n, .sclk, .din, .dout,
		.dout_oe_n, .raw_rate, .status_in, .cal_rate, .angle_clear, .dac_latch_q,
		.alarm1_threshold(rp[0]), .alarm2_threshold(rp[1]), .alarm1_sample_period(rp[2]),
		.alarm2_sample_period(rp[3]), .alarm_source_control(rp[4]), .pin_io_control(rp[5]),
		.misc_control(rp[6]), .sample_period_control(rp[7]),
		.range_and_filter_control(rp[8]), .sleep_duration(rp[9]), .flash_busy);
	gcr_host host_inst (.clk_sys, .cs_n, .sclk, .din, .dout, .dout_oe_n);
	always @(posedge clk_sys) if (angle_clear === 1'b1) n_clr++;
	task automatic chk(string n, logic [15:0] x, logic [15:0] s);
		tests_run++;
		if (s !== x) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	function automatic bit wok(logic [5:0] a);
		return a inside {[6'h10:6'h13], [6'h20:6'h29], [6'h30:6'h3B]};
	endfunction
	task automatic wr(logic [5:0] a, logic [7:0] d);
		host_inst.xfer({2'b10, a, d}, rx);
		if (wok(a) && a[0]) m[a[5:1]][15:8] = d;
		else if (wok(a)) m[a[5:1]][7:0] = d;
		if (a[5:2] == 4'h4) m[a[5:1]] &= 16'h0FFF;
	endtask
	task automatic rd(logic [5:0] a, string n);
		logic [15:0] x;
		x = wok(a) ? m[a[5:1]] : (a[5:1] == 5'h1E ? status_in : 16'h0000);
		if (a[5:1] == 5'h00) x = 16'(n_end);
		host_inst.xfer({2'b00, a, 8'h00}, rx);
		host_inst.xfer(16'h0000, rx);
		chk(n, x, rx);
	endtask
	task automatic w_idle;
		int k = 0;
		repeat (3) @(posedge clk_sys);
		while (flash_busy !== 1'b0 && k < 4 * FC) begin
			k++;
			@(posedge clk_sys);
		end
		chk("flash busy", 16'h0000, {15'h0000, flash_busy});
	endtask
	task automatic cmd(logic [7:0] c, int f);
		wr(6'h3E, c);
		n_end += f;
		w_idle();
		rd(6'h00, "endurance");
	endtask
	task automatic ports(string n);
		for (int i = 0; i < 10; i++) chk(n, m[pa[i][5:1]], rp[i]);
	endtask
	task automatic fin(string n);
		$display("Test %s ended, %0d mismatches so far", n, n_fail);
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		raw_rate = 14'h0000;
		status_in = 16'($random(seed));
		foreach (m[i]) m[i] = 16'h0000;
		repeat (10) @(posedge clk_sys);
		#1 rst = 1'b0;
		w_idle();
		for (logic [6:0] a = 7'h10; a < 7'h3E; a++)
			if (a[5:2] != 4'h5) wr(a[5:0], 8'($random(seed)));
		for (logic [6:0] a = 7'h10; a < 7'h40; a += 7'h02)
			if (a[5:2] != 4'h5) rd(a[5:0] | {5'h00, a[2]}, "register");
		ports("register port");
		fin("map");
		repeat (8) begin
			@(posedge clk_sys) #1 raw_rate = 14'($random(seed) & 32'h7FF);
			repeat (2) @(posedge clk_sys);
			e = int'(raw_rate) * int'(m[9]) / 2048 + int'($signed(m[8][11:0]));
			chk("cal_rate", {2'b00, 14'(e)}, {2'b00, cal_rate});
		end
		fin("calibration");
		wr(6'h3E, 8'h08);
		cmd(8'h02, 1);
		rd(6'h12, "scale");
		wr(6'h3F, 8'hFF);
		cmd(8'h00, 0);
		ports("after idle commands");
		fin("flash update");
		wr(6'h30, 8'h5A);
		wr(6'h31, 8'hC3);
		chk("dac latch", 16'h0000, {4'h0, dac_latch_q});
		cmd(8'h04, 0);
		chk("dac latch", {4'h0, m[24][11:0]}, {4'h0, dac_latch_q});
		fin("dac");
		cmd(8'h02, 1);
		m[8] = 16'h0000;
		m[9] = 16'h0800;
		rd(6'h10, "offset");
		rd(6'h13, "scale");
		wr(6'h38, 8'h07);
		cmd(8'h01, 1);
		m[8] = 16'((-int'(raw_rate)) & 32'hFFF);
		rd(6'h11, "offset");
		chk("angle clears", 16'h0001, 16'(n_clr));
		fin("calibration commands");
		cmd(8'h80, 0);
		m[24] = 16'h0000;
		m[25] = 16'h0000;
		m[29] = 16'h0000;
		m[26][7:0] = 8'h00;
		ports("after soft reset");
		rd(6'h10, "offset");
		chk("dac latch", 16'h0000, {4'h0, dac_latch_q});
		fin("soft reset");
		stop_test();
	end
endmodule
`default_nettype wire
